// *** hw/pcg_pkg.sv ***
// Function
// - Eight enable bits gate ports A to H
// - Clear bit stops clock, holds port disabled
// - Access to gated port answers bus fault
// - Register resets to zero, ports unclocked
// - Register at 0x108, bits 31:8 read zero
// - Run register gates ports while running
// - Sleep gating applies only with auto gating
package pcg_pkg;

   // =========================================================
   // Register map
   localparam logic [11:0] RUN_GATE_OFS   = 12'h108;
   localparam logic [11:0] SLEEP_GATE_OFS = 12'h118;
   localparam logic [11:0] DEEP_GATE_OFS  = 12'h128;
   localparam logic [11:0] RUN_CFG_OFS    = 12'h060;
   localparam logic [11:0] IRQ_STAT_OFS   = 12'h200;
   localparam logic [11:0] IRQ_EN_OFS     = 12'h204;
   localparam logic [11:0] IRQ_CLR_OFS    = 12'h208;

   // =========================================================
   // Fields and reset values
   localparam int          NUM_PORTS      = 8;
   localparam int          AUTO_GATE_BIT  = 27;
   localparam logic [7:0]  GATE_RST       = 8'h00;
   localparam logic [31:0] RUN_CFG_RST    = 32'h00000000;
   localparam int          IRQ_FAULT_BIT  = 0;
   localparam int          IRQ_WAKE_BIT   = 1;
   localparam logic [1:0]  IRQ_RST        = 2'h0;

   // =========================================================
   // Power states
   typedef enum logic [1:0] {
      PCG_RUN   = 2'b00,
      PCG_SLEEP = 2'b01,
      PCG_DEEP  = 2'b10
   } pcg_pwr_e;

endpackage

// *** hw/pcg_port_gate.sv ***
`timescale 1ns/1ps
// Gate for one port: registered enable, access check and fault flag.
module pcg_port_gate (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Control
   input  wire logic gate_on,
   input  wire logic acc,
   // Outputs
   output logic      clk_en_q,
   output logic      fault_q
);

   logic clk_en_d;
   logic fault_d;

   // =========================================================
   // Next values
   always_comb begin
      clk_en_d = gate_on;
      fault_d  = acc & ~clk_en_q;
   end

   // Registered so the gate enable is glitch free
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_en_q <= 1'b0;
         fault_q  <= 1'b0;
      end else begin
         clk_en_q <= clk_en_d;
         fault_q  <= fault_d;
      end
   end

endmodule

// *** hw/pcg_top.sv ***
`timescale 1ns/1ps
// Port clock gating control: run, sleep and deep-sleep gating registers.
module pcg_top #(
   parameter int NPORT = pcg_pkg::NUM_PORTS
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // Register port
   input  wire logic [11:0]       reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   // Power state from the core
   input  wire logic              sleep_req,
   input  wire logic              deep_sleep_req,
   // Port access requests from the bus fabric
   input  wire logic [NPORT-1:0]  port_acc,
   // Port clock enables and fault answers
   output logic      [NPORT-1:0]  port_clk_en,
   output logic      [NPORT-1:0]  port_fault,
   output logic                   bus_fault,
   // Interrupt
   output logic                   irq
);

   // =========================================================
   // Address match helper, used by every register decode
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   // =========================================================
   // Software registers
   logic [NPORT-1:0] run_gate_q,   run_gate_d;
   logic [NPORT-1:0] sleep_gate_q, sleep_gate_d;
   logic [NPORT-1:0] deep_gate_q,  deep_gate_d;
   logic [31:0]      run_cfg_q,    run_cfg_d;
   logic [1:0]       irq_stat_q,   irq_stat_d;
   logic [1:0]       irq_en_q,     irq_en_d;
   logic [31:0]      reg_rdata_d;
   logic             irq_d;
   logic             bus_fault_d;

   // Writes; only bits 7:0 of the gate registers store anything
   always_comb begin
      run_gate_d   = run_gate_q;
      sleep_gate_d = sleep_gate_q;
      deep_gate_d  = deep_gate_q;
      run_cfg_d    = run_cfg_q;
      irq_en_d     = irq_en_q;
      if (reg_wr) begin
         if (hit(reg_addr, pcg_pkg::RUN_GATE_OFS)) begin
            run_gate_d = reg_wdata[NPORT-1:0];
         end
         if (hit(reg_addr, pcg_pkg::SLEEP_GATE_OFS)) begin
            sleep_gate_d = reg_wdata[NPORT-1:0];
         end
         if (hit(reg_addr, pcg_pkg::DEEP_GATE_OFS)) begin
            deep_gate_d = reg_wdata[NPORT-1:0];
         end
         if (hit(reg_addr, pcg_pkg::RUN_CFG_OFS)) begin
            run_cfg_d = reg_wdata;
         end
         if (hit(reg_addr, pcg_pkg::IRQ_EN_OFS)) begin
            irq_en_d = reg_wdata[1:0];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_gate_q   <= pcg_pkg::GATE_RST;
         sleep_gate_q <= pcg_pkg::GATE_RST;
         deep_gate_q  <= pcg_pkg::GATE_RST;
         run_cfg_q    <= pcg_pkg::RUN_CFG_RST;
         irq_en_q     <= pcg_pkg::IRQ_RST;
      end else begin
         run_gate_q   <= run_gate_d;
         sleep_gate_q <= sleep_gate_d;
         deep_gate_q  <= deep_gate_d;
         run_cfg_q    <= run_cfg_d;
         irq_en_q     <= irq_en_d;
      end
   end

   // =========================================================
   // Power state and effective gate selection
   pcg_pkg::pcg_pwr_e pwr_q, pwr_d;
   logic [NPORT-1:0]  gate_sel;
   logic              auto_gate;

   assign auto_gate = run_cfg_q[pcg_pkg::AUTO_GATE_BIT];

   // Deep sleep wins over sleep when both are asked for
   always_comb begin
      if (deep_sleep_req) begin
         pwr_d = pcg_pkg::PCG_DEEP;
      end else if (sleep_req) begin
         pwr_d = pcg_pkg::PCG_SLEEP;
      end else begin
         pwr_d = pcg_pkg::PCG_RUN;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_q <= pcg_pkg::PCG_RUN;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   // Sleep registers only count with auto gating; else run register rules
   always_comb begin
      case (pwr_q)
         pcg_pkg::PCG_RUN: begin
            gate_sel = run_gate_q;
         end
         pcg_pkg::PCG_SLEEP: begin
            gate_sel = auto_gate ? sleep_gate_q : run_gate_q;
         end
         pcg_pkg::PCG_DEEP: begin
            gate_sel = auto_gate ? deep_gate_q : run_gate_q;
         end
         default: begin
            gate_sel = run_gate_q;
         end
      endcase
   end

   // =========================================================
   // One gate per port
   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi++) begin : g_port
         pcg_port_gate u_gate (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .gate_on  (gate_sel[gi]),
            .acc      (port_acc[gi]),
            .clk_en_q (port_clk_en[gi]),
            .fault_q  (port_fault[gi])
         );
      end
   endgenerate

   // =========================================================
   // Interrupt status: fault event and wake event, set beats clear
   logic fault_evt;
   logic wake_evt;
   logic [1:0] evt;
   logic [1:0] clr;

   // Judged against the live clock enable, so it agrees with the port gates
   assign fault_evt = |(port_acc & ~port_clk_en);
   assign wake_evt  = (pwr_q != pcg_pkg::PCG_RUN) & (pwr_d == pcg_pkg::PCG_RUN);
   assign evt       = {wake_evt, fault_evt};
   assign clr       = (reg_wr && hit(reg_addr, pcg_pkg::IRQ_CLR_OFS)) ? reg_wdata[1:0] : 2'h0;

   always_comb begin
      irq_stat_d  = (irq_stat_q & ~clr) | evt;
      irq_d       = |(irq_stat_d & irq_en_d);
      bus_fault_d = fault_evt;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= pcg_pkg::IRQ_RST;
         irq        <= 1'b0;
         bus_fault  <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq        <= irq_d;
         bus_fault  <= bus_fault_d;
      end
   end

   // =========================================================
   // Read path; reserved and unmapped bits read zero
   always_comb begin
      reg_rdata_d = 32'h00000000;
      if (reg_rd) begin
         if (hit(reg_addr, pcg_pkg::RUN_GATE_OFS)) begin
            reg_rdata_d[NPORT-1:0] = run_gate_q;
         end else if (hit(reg_addr, pcg_pkg::SLEEP_GATE_OFS)) begin
            reg_rdata_d[NPORT-1:0] = sleep_gate_q;
         end else if (hit(reg_addr, pcg_pkg::DEEP_GATE_OFS)) begin
            reg_rdata_d[NPORT-1:0] = deep_gate_q;
         end else if (hit(reg_addr, pcg_pkg::RUN_CFG_OFS)) begin
            reg_rdata_d = run_cfg_q;
         end else if (hit(reg_addr, pcg_pkg::IRQ_STAT_OFS)) begin
            reg_rdata_d[1:0] = irq_stat_q;
         end else if (hit(reg_addr, pcg_pkg::IRQ_EN_OFS)) begin
            reg_rdata_d[1:0] = irq_en_q;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= reg_rdata_d;
      end
   end

endmodule

// *** sim/pcg_properties.sv ***
`timescale 1ns/1ps
// ==========
// Port clock gating checker
module pcg_properties #(
   parameter int NPORT = 8
) (
   // Clock, reset, register port
   input wire logic             core_clk,
   input wire logic             rst_n,
   input wire logic [11:0]      reg_addr,
   input wire logic [31:0]      reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [31:0]      reg_rdata,
   // Power state
   input wire logic             sleep_req,
   input wire logic             deep_sleep_req,
   // Ports and answers
   input wire logic [NPORT-1:0] port_acc,
   input wire logic [NPORT-1:0] port_clk_en,
   input wire logic [NPORT-1:0] port_fault,
   input wire logic             bus_fault,
   input wire logic             irq
);
   logic [NPORT-1:0] run_q, slp_q, dp_q, exp_en;
   logic             auto_q;
   logic             run_lvl;
   // Plain level form of the run state, for use inside expressions
   assign run_lvl = !sleep_req && !deep_sleep_req;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Shadow of the gate registers, so steady states can be judged
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {run_q, slp_q, dp_q, auto_q} <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            pcg_pkg::RUN_GATE_OFS: run_q <= reg_wdata[NPORT-1:0];
            pcg_pkg::SLEEP_GATE_OFS: slp_q <= reg_wdata[NPORT-1:0];
            pcg_pkg::DEEP_GATE_OFS: dp_q <= reg_wdata[NPORT-1:0];
            pcg_pkg::RUN_CFG_OFS: auto_q <= reg_wdata[pcg_pkg::AUTO_GATE_BIT];
            default: ;
         endcase
      end
   end
   // Deep beats sleep; without auto gating the run register rules
   assign exp_en = !auto_q ? run_q : deep_sleep_req ? dp_q : sleep_req ? slp_q : run_q;
   // Three cycles with no write and a steady power state
   sequence quiet3;
      (!reg_wr && $stable(sleep_req) && $stable(deep_sleep_req))[*3];
   endsequence
   sequence in_run;
      run_lvl;
   endsequence
   chk_run_gate: assert property (quiet3 ##0 in_run |-> port_clk_en == run_q)
      else $error("run gate not applied");
   chk_sleep_noauto: assert property (quiet3 ##0 (sleep_req && !auto_q) |-> port_clk_en == run_q)
      else $error("run gate lost in sleep");
   chk_sleep_auto: assert property (quiet3 ##0 (auto_q && !run_lvl) |-> port_clk_en == exp_en)
      else $error("sleep gate wrong");
   chk_write_lag: assert property (reg_wr && reg_addr == pcg_pkg::RUN_GATE_OFS && run_lvl ##1 in_run
      |=> port_clk_en == $past(reg_wdata[NPORT-1:0], 2)) else $error("gate lag wrong");
   chk_fault_gated: assert property ((port_acc & ~port_clk_en) != '0
      |=> bus_fault && port_fault == $past(port_acc & ~port_clk_en)) else $error("no fault");
   chk_no_fault: assert property ((port_acc & ~port_clk_en) == '0 |=> !bus_fault)
      else $error("spurious fault");
   chk_read_upper: assert property (reg_rd && reg_addr == pcg_pkg::RUN_GATE_OFS
      |=> reg_rdata == 32'(run_q)) else $error("run gate read wrong");
   chk_reset_zero: assert property ($rose(rst_n) |-> port_clk_en == '0 ##1 port_clk_en == '0)
      else $error("port clocked after reset");
endmodule
bind pcg_top pcg_properties #(.NPORT(NPORT)) chk_u (.core_clk, .rst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .sleep_req, .deep_sleep_req, .port_acc, .port_clk_en,
   .port_fault, .bus_fault, .irq);

// *** sim/run_mode_port_clock_gating_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
// ==========
// Port clock gating bench
module run_mode_port_clock_gating_bench;
   logic        core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
   logic        sleep_req = 0, deep_sleep_req = 0, bus_fault, irq;
   logic [11:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata;
   logic [7:0]  port_acc = '0, port_clk_en, port_fault;
   int          mismatches = 0, n_checks = 0;
   // Value written to the run gate, value read back
   logic [31:0] rows [4][2] = '{'{32'hffffffff, 32'hff}, '{32'h155, 32'h55},
                                '{32'haa, 32'haa}, '{32'h0, 32'h0}};
   always #10 core_clk = ~core_clk;
   pcg_top dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .sleep_req, .deep_sleep_req, .port_acc, .port_clk_en, .port_fault, .bus_fault, .irq);
   // One-cycle register write
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand one cycle only, so they are taken at once
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog, far beyond the fewer than a hundred cycles the tests need
   initial begin
      repeat (3000) @(posedge core_clk);
      mismatches++;
      final_report;
   end
   initial begin
      logic [31:0] d;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(pcg_pkg::RUN_GATE_OFS, d);
      `CHK(d, 32'h0)
      `CHK(port_clk_en, 8'h00)
      // Table: write, read back, gate follows, gated ports fault
      foreach (rows[i]) begin
         wr(pcg_pkg::RUN_GATE_OFS, rows[i][0]);
         rd(pcg_pkg::RUN_GATE_OFS, d);
         `CHK(d, rows[i][1])
         `CHK(port_clk_en, rows[i][1][7:0])
         @(posedge core_clk);
         port_acc <= 8'hff;
         @(posedge core_clk);
         port_acc <= 8'h00;
         #1 `CHK(port_fault, ~rows[i][1][7:0])
         `CHK(bus_fault, rows[i][1] != 32'hff)
      end
      rd(12'h3fc, d);
      `CHK(d, 32'h0)
      // Interrupt from the faults above: raise, mask, clear
      wr(pcg_pkg::IRQ_EN_OFS, 32'h1);
      idle(2);
      `CHK(irq, 1'b1)
      wr(pcg_pkg::IRQ_EN_OFS, 32'h0);
      idle(2);
      `CHK(irq, 1'b0)
      rd(pcg_pkg::IRQ_STAT_OFS, d);
      `CHK(d[0], 1'b1)
      wr(pcg_pkg::IRQ_CLR_OFS, 32'h1);
      wr(pcg_pkg::IRQ_EN_OFS, 32'h1);
      idle(2);
      `CHK(irq, 1'b0)
      // Power states with and without auto gating
      wr(pcg_pkg::RUN_GATE_OFS, 32'hf0);
      wr(pcg_pkg::SLEEP_GATE_OFS, 32'h0f);
      sleep_req <= 1'b1;
      idle(3);
      `CHK(port_clk_en, 8'hf0)
      wr(pcg_pkg::RUN_CFG_OFS, 32'h1 << pcg_pkg::AUTO_GATE_BIT);
      idle(3);
      `CHK(port_clk_en, 8'h0f)
      @(posedge core_clk);
      deep_sleep_req <= 1'b1;
      idle(3);
      `CHK(port_clk_en, 8'h00)
      @(posedge core_clk);
      sleep_req <= 1'b0;
      deep_sleep_req <= 1'b0;
      idle(3);
      `CHK(port_clk_en, 8'hf0)
      // Reset in mid-run drops every gate
      @(posedge core_clk);
      rst_n <= 1'b0;
      idle(2);
      `CHK(port_clk_en, 8'h00)
      @(posedge core_clk);
      rst_n <= 1'b1;
      // Enable port A before touching it, keeping upper bits as read
      rd(pcg_pkg::RUN_GATE_OFS, d);
      `CHK(d, 32'h0)
      wr(pcg_pkg::RUN_GATE_OFS, (d & 32'hffffff00) | 32'h1);
      idle(2);
      `CHK(port_clk_en, 8'h01)
      @(posedge core_clk);
      port_acc <= 8'h01;
      @(posedge core_clk);
      port_acc <= 8'h00;
      #1 `CHK(port_fault, 8'h00)
      final_report;
   end
endmodule
